// *** inc/cca_consts.vh ***
`ifndef CCA_CONSTS_VH
`define CCA_CONSTS_VH

// Configuration address register fields
`define CCA_ADDR_EN_BIT 31
`define CCA_ADDR_BUS_HI 23
`define CCA_ADDR_BUS_LO 16
`define CCA_ADDR_DEV_HI 15
`define CCA_ADDR_DEV_LO 11
`define CCA_ADDR_FUN_HI 10
`define CCA_ADDR_FUN_LO 8
`define CCA_ADDR_IDX_HI 7
`define CCA_ADDR_IDX_LO 2
`define CCA_ADDR_KEEP_MASK 32'h80FF_FFFC

// Logical bus, device and function numbers
`define CCA_BUS_ZERO 8'h00
`define CCA_DEV_HOST 5'h00
`define CCA_DEV_P2P 5'h01
`define CCA_DEV_GFX 5'h02
`define CCA_FUN_LEGACY 3'h0
`define CCA_FUN_DRAM 3'h1
`define CCA_FUN_PROC 3'h3

// Dword indexes
`define CCA_IDX_ID 6'h00
`define CCA_IDX_CMD 6'h01
`define CCA_IDX_BUSNUM 6'h06
`define CCA_IDX_IOWIN 6'h07
`define CCA_IDX_MEMWIN 6'h08
`define CCA_IDX_SCRATCH 6'h10
`define CCA_IDX_CTL 6'h14
`define CCA_IDX_LOCKED 6'h15
`define CCA_IDX_DRAM 6'h18

// Field masks
`define CCA_CMD_RW_MASK 32'h0000_0006
`define CCA_CMD_WC_MASK 32'h3000_0000
`define CCA_CTL_WO_MASK 32'h00FF_0001
`define CCA_CTL_RW_MASK 32'h0000_FF00
`define CCA_CTL_LOCK_BIT 0
`define CCA_BUSNUM_RW_MASK 32'h00FF_FF00
`define CCA_IOWIN_RW_MASK 32'h0000_F0F0
`define CCA_MEMWIN_RW_MASK 32'hFFF0_FFF0
`define CCA_ALL_MASK 32'hFFFF_FFFF
`define CCA_NONE_MASK 32'h0000_0000
`define CCA_STRAP_MASK 32'h0000_00FF

// Reset values
`define CCA_CMD_RST 32'h0000_0000
`define CCA_CTL_RST 32'h0000_0400
`define CCA_BUSNUM_RST 32'h0000_0000
`define CCA_IOWIN_RST 32'h0000_00F0
`define CCA_MEMWIN_RST 32'h0000_FFF0
`define CCA_DRAM_RST 32'h0000_0000
`define CCA_ZERO 32'h0000_0000
`define CCA_UNCLAIMED 32'hFFFF_FFFF

`endif

// *** logic/cca_attr_reg.v ***
`timescale 1ns/1ps
`include "cca_consts.vh"

module cca_attr_reg #(
    parameter [31:0] RST_VAL = 32'h0000_0000,
    parameter [31:0] RW_MASK = 32'h0000_0000,
    parameter [31:0] WC_MASK = 32'h0000_0000,
    parameter [31:0] WO_MASK = 32'h0000_0000,
    parameter [31:0] LK_MASK = 32'h0000_0000,
    parameter [31:0] LD_MASK = 32'h0000_0000
) (
    // Clock and resets
    input wire clk_i,
    input wire reset_i,
    input wire por_i,
    // Write side
    input wire we_i,
    input wire [3:0] be_i,
    input wire [31:0] wdata_i,
    input wire lock_i,
    // Hardware side
    input wire [31:0] set_i,
    input wire load_i,
    input wire [31:0] load_val_i,
    // Contents
    output reg [31:0] q_o
);
    reg [31:0] wo_done_q;
    reg [31:0] q_d;
    reg [31:0] wo_done_d;
    reg [31:0] wm;
    reg [31:0] wo_ok;
    reg [31:0] lk_ok;
    reg [31:0] wc_clr;
    reg [31:0] ld;

    always @* begin
        wm = {{8{be_i[3]}}, {8{be_i[2]}}, {8{be_i[1]}}, {8{be_i[0]}}} & {32{we_i}};
        wo_ok = wm & WO_MASK & ~wo_done_q; // see [R7]
        lk_ok = wm & LK_MASK & {32{~lock_i}}; // see [R8]
        wc_clr = wm & WC_MASK & wdata_i; // see [R6]
        ld = LD_MASK & {32{load_i}};
        // Bits in no mask keep their value on writes
        q_d = (q_o & ~(wm & RW_MASK)) | (wdata_i & wm & RW_MASK); // see [R5]
        q_d = (q_d & ~wo_ok) | (wdata_i & wo_ok);
        q_d = (q_d & ~lk_ok) | (wdata_i & lk_ok);
        q_d = (q_d & ~wc_clr) | (set_i & WC_MASK);
        q_d = (q_d & ~ld) | (load_val_i & ld); // see [R14]
        wo_done_d = wo_done_q | wo_ok;
    end

    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            q_o <= RST_VAL; // see [R13]
        end else begin
            q_o <= q_d;
        end
    end

    // Only power-up clears the once-written record
    always @(posedge clk_i or posedge por_i) begin
        if (por_i) begin
            wo_done_q <= 32'h0000_0000; // see [R16]
        end else begin
            wo_done_q <= wo_done_d;
        end
    end
endmodule // cca_attr_reg

// *** logic/cca_cfg_space.v ***
// Contract
// [R1] Internal functions appear as devices on logical bus zero only.
// [R2] Device zero answers on functions zero, one and three.
// [R3] Device one is a bridge header with I/O and memory windows.
// [R4] Device two graphics exists only when the graphics variant is built.
// [R5] Writes to read-only bits leave contents unchanged.
// [R6] Writing one clears a write-clear bit; writing zero does nothing.
// [R7] Write-once bits accept only the first write after power-up.
// [R8] Lockable bits are writable until the lock bit is set.
// [R9] Reserved locations of device zero complete and read zero.
// [R10] Software preserves reserved bits by read-merge-write.
// [R11] Configuration address register may be written directly.
// [R12] Software never modifies vendor-reserved registers.
// [R13] Reset loads every register with its default.
// [R14] Some defaults come from strap inputs sampled after reset.
// [R15] Data window works only when address bit 31 is set.
// [R16] Write-once record is cleared only by power-up reset.
`timescale 1ns/1ps
`include "cca_consts.vh"

module cca_cfg_space #(
    parameter HAS_GFX = 1,
    parameter STRAP_W = 8,
    // Identity values are arbitrary
    parameter [31:0] ID_HOST = 32'h0100_1234,
    parameter [31:0] ID_DRAM = 32'h0101_1234,
    parameter [31:0] ID_PROC = 32'h0103_1234,
    parameter [31:0] ID_P2P = 32'h0110_1234,
    parameter [31:0] ID_GFX = 32'h0120_1234
) (
    // Clock and resets
    input wire clk_i,
    input wire reset_i,
    input wire por_i,
    // Straps and hardware events
    input wire [STRAP_W-1:0] strap_i,
    input wire [1:0] err_evt_i,
    // Configuration address register
    input wire addr_we_i,
    input wire [31:0] addr_wdata_i,
    output reg [31:0] addr_rdata_o,
    // Configuration data window
    input wire data_req_i,
    input wire data_we_i,
    input wire [3:0] data_be_i,
    input wire [31:0] data_wdata_i,
    output reg [31:0] data_rdata_o,
    output reg data_ack_o,
    output reg data_hit_o
);
    reg strap_pend_q;
    reg [31:0] rd;
    reg hit;
    wire [7:0] bus_n;
    wire [4:0] dev_n;
    wire [2:0] fun_n;
    wire [5:0] idx;
    wire sel_host;
    wire sel_dram;
    wire sel_proc;
    wire sel_p2p;
    wire sel_gfx;
    wire wr;
    wire [31:0] strap_val;
    wire [31:0] host_cmd;
    wire [31:0] host_ctl;
    wire [31:0] host_locked;
    wire [31:0] dram_q;
    wire [31:0] proc_q;
    wire [31:0] p2p_cmd;
    wire [31:0] p2p_bus;
    wire [31:0] p2p_io;
    wire [31:0] p2p_mem;
    wire [31:0] gfx_cmd;

    assign bus_n = addr_rdata_o[`CCA_ADDR_BUS_HI:`CCA_ADDR_BUS_LO];
    assign dev_n = addr_rdata_o[`CCA_ADDR_DEV_HI:`CCA_ADDR_DEV_LO];
    assign fun_n = addr_rdata_o[`CCA_ADDR_FUN_HI:`CCA_ADDR_FUN_LO];
    assign idx = addr_rdata_o[`CCA_ADDR_IDX_HI:`CCA_ADDR_IDX_LO];

    // Internal functions live on logical bus zero only
    wire on_bus0 = addr_rdata_o[`CCA_ADDR_EN_BIT] && (bus_n == `CCA_BUS_ZERO); // see [R1] [R15]
    assign sel_host = on_bus0 && (dev_n == `CCA_DEV_HOST) && (fun_n == `CCA_FUN_LEGACY); // see [R2]
    assign sel_dram = on_bus0 && (dev_n == `CCA_DEV_HOST) && (fun_n == `CCA_FUN_DRAM);
    assign sel_proc = on_bus0 && (dev_n == `CCA_DEV_HOST) && (fun_n == `CCA_FUN_PROC);
    assign sel_p2p = on_bus0 && (dev_n == `CCA_DEV_P2P) && (fun_n == `CCA_FUN_LEGACY); // see [R3]
    assign sel_gfx = (HAS_GFX != 0) && on_bus0 && (dev_n == `CCA_DEV_GFX) && (fun_n == `CCA_FUN_LEGACY); // see [R4]
    assign wr = data_req_i && data_we_i;
    assign strap_val = {{(32-STRAP_W){1'b0}}, strap_i};

    // Address register written whole, no merge needed
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            addr_rdata_o <= `CCA_ZERO;
        end else if (addr_we_i) begin
            addr_rdata_o <= addr_wdata_i & `CCA_ADDR_KEEP_MASK; // see [R11]
        end
    end

    // Straps are caught on the first edge after release
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            strap_pend_q <= 1'b1;
        end else begin
            strap_pend_q <= 1'b0; // see [R14]
        end
    end

    cca_attr_reg #(.RST_VAL(`CCA_CMD_RST), .RW_MASK(`CCA_CMD_RW_MASK), .WC_MASK(`CCA_CMD_WC_MASK))
    u_host_cmd (
        .clk_i(clk_i), .reset_i(reset_i), .por_i(por_i),
        .we_i(wr && sel_host && (idx == `CCA_IDX_CMD)), .be_i(data_be_i), .wdata_i(data_wdata_i),
        .lock_i(1'b0), .set_i({2'b00, err_evt_i, 28'h000_0000}), // see [R6]
        .load_i(1'b0), .load_val_i(`CCA_ZERO), .q_o(host_cmd)
    );

    cca_attr_reg #(.RST_VAL(`CCA_CTL_RST), .RW_MASK(`CCA_CTL_RW_MASK), .WO_MASK(`CCA_CTL_WO_MASK))
    u_host_ctl (
        .clk_i(clk_i), .reset_i(reset_i), .por_i(por_i),
        .we_i(wr && sel_host && (idx == `CCA_IDX_CTL)), .be_i(data_be_i), .wdata_i(data_wdata_i),
        .lock_i(1'b0), .set_i(`CCA_ZERO),
        .load_i(1'b0), .load_val_i(`CCA_ZERO), .q_o(host_ctl)
    );

    cca_attr_reg #(.RST_VAL(`CCA_ZERO), .LK_MASK(`CCA_ALL_MASK))
    u_host_locked (
        .clk_i(clk_i), .reset_i(reset_i), .por_i(por_i),
        .we_i(wr && sel_host && (idx == `CCA_IDX_LOCKED)), .be_i(data_be_i), .wdata_i(data_wdata_i),
        .lock_i(host_ctl[`CCA_CTL_LOCK_BIT]), .set_i(`CCA_ZERO), // see [R8]
        .load_i(1'b0), .load_val_i(`CCA_ZERO), .q_o(host_locked)
    );

    cca_attr_reg #(.RST_VAL(`CCA_DRAM_RST), .RW_MASK(`CCA_ALL_MASK), .LD_MASK(`CCA_STRAP_MASK))
    u_dram (
        .clk_i(clk_i), .reset_i(reset_i), .por_i(por_i),
        .we_i(wr && sel_dram && (idx == `CCA_IDX_DRAM)), .be_i(data_be_i), .wdata_i(data_wdata_i),
        .lock_i(1'b0), .set_i(`CCA_ZERO),
        .load_i(strap_pend_q), .load_val_i(strap_val), .q_o(dram_q) // see [R14]
    );

    cca_attr_reg #(.RST_VAL(`CCA_ZERO), .RW_MASK(`CCA_ALL_MASK))
    u_proc (
        .clk_i(clk_i), .reset_i(reset_i), .por_i(por_i),
        .we_i(wr && sel_proc && (idx == `CCA_IDX_SCRATCH)), .be_i(data_be_i), .wdata_i(data_wdata_i),
        .lock_i(1'b0), .set_i(`CCA_ZERO),
        .load_i(1'b0), .load_val_i(`CCA_ZERO), .q_o(proc_q)
    );

    cca_attr_reg #(.RST_VAL(`CCA_CMD_RST), .RW_MASK(`CCA_CMD_RW_MASK), .WC_MASK(`CCA_CMD_WC_MASK))
    u_p2p_cmd (
        .clk_i(clk_i), .reset_i(reset_i), .por_i(por_i),
        .we_i(wr && sel_p2p && (idx == `CCA_IDX_CMD)), .be_i(data_be_i), .wdata_i(data_wdata_i),
        .lock_i(1'b0), .set_i(`CCA_ZERO),
        .load_i(1'b0), .load_val_i(`CCA_ZERO), .q_o(p2p_cmd)
    );

    // Primary bus number stays zero
    cca_attr_reg #(.RST_VAL(`CCA_BUSNUM_RST), .RW_MASK(`CCA_BUSNUM_RW_MASK))
    u_p2p_bus (
        .clk_i(clk_i), .reset_i(reset_i), .por_i(por_i),
        .we_i(wr && sel_p2p && (idx == `CCA_IDX_BUSNUM)), .be_i(data_be_i), .wdata_i(data_wdata_i),
        .lock_i(1'b0), .set_i(`CCA_ZERO),
        .load_i(1'b0), .load_val_i(`CCA_ZERO), .q_o(p2p_bus)
    );

    cca_attr_reg #(.RST_VAL(`CCA_IOWIN_RST), .RW_MASK(`CCA_IOWIN_RW_MASK))
    u_p2p_io (
        .clk_i(clk_i), .reset_i(reset_i), .por_i(por_i),
        .we_i(wr && sel_p2p && (idx == `CCA_IDX_IOWIN)), .be_i(data_be_i), .wdata_i(data_wdata_i),
        .lock_i(1'b0), .set_i(`CCA_ZERO),
        .load_i(1'b0), .load_val_i(`CCA_ZERO), .q_o(p2p_io)
    );

    cca_attr_reg #(.RST_VAL(`CCA_MEMWIN_RST), .RW_MASK(`CCA_MEMWIN_RW_MASK))
    u_p2p_mem (
        .clk_i(clk_i), .reset_i(reset_i), .por_i(por_i),
        .we_i(wr && sel_p2p && (idx == `CCA_IDX_MEMWIN)), .be_i(data_be_i), .wdata_i(data_wdata_i),
        .lock_i(1'b0), .set_i(`CCA_ZERO),
        .load_i(1'b0), .load_val_i(`CCA_ZERO), .q_o(p2p_mem)
    );

    cca_attr_reg #(.RST_VAL(`CCA_CMD_RST), .RW_MASK(`CCA_CMD_RW_MASK), .WC_MASK(`CCA_CMD_WC_MASK))
    u_gfx_cmd (
        .clk_i(clk_i), .reset_i(reset_i), .por_i(por_i),
        .we_i(wr && sel_gfx && (idx == `CCA_IDX_CMD)), .be_i(data_be_i), .wdata_i(data_wdata_i),
        .lock_i(1'b0), .set_i(`CCA_ZERO),
        .load_i(1'b0), .load_val_i(`CCA_ZERO), .q_o(gfx_cmd)
    );

    // Read mux; reserved locations of a claimed function read zero
    always @* begin
        rd = `CCA_ZERO; // see [R9]
        hit = sel_host || sel_dram || sel_proc || sel_p2p || sel_gfx;
        if (sel_host) begin
            case (idx)
                `CCA_IDX_ID: rd = ID_HOST;
                `CCA_IDX_CMD: rd = host_cmd;
                `CCA_IDX_CTL: rd = host_ctl;
                `CCA_IDX_LOCKED: rd = host_locked;
                default: rd = `CCA_ZERO;
            endcase
        end else if (sel_dram) begin
            case (idx)
                `CCA_IDX_ID: rd = ID_DRAM;
                `CCA_IDX_DRAM: rd = dram_q;
                default: rd = `CCA_ZERO;
            endcase
        end else if (sel_proc) begin
            case (idx)
                `CCA_IDX_ID: rd = ID_PROC;
                `CCA_IDX_SCRATCH: rd = proc_q;
                default: rd = `CCA_ZERO;
            endcase
        end else if (sel_p2p) begin
            case (idx)
                `CCA_IDX_ID: rd = ID_P2P;
                `CCA_IDX_CMD: rd = p2p_cmd;
                `CCA_IDX_BUSNUM: rd = p2p_bus;
                `CCA_IDX_IOWIN: rd = p2p_io;
                `CCA_IDX_MEMWIN: rd = p2p_mem;
                default: rd = `CCA_ZERO;
            endcase
        end else if (sel_gfx) begin
            case (idx)
                `CCA_IDX_ID: rd = ID_GFX;
                `CCA_IDX_CMD: rd = gfx_cmd;
                default: rd = `CCA_ZERO;
            endcase
        end else begin
            rd = `CCA_UNCLAIMED; // see [R15]
        end
    end

    // Every window access completes one cycle later
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            data_rdata_o <= `CCA_ZERO;
            data_ack_o <= 1'b0;
            data_hit_o <= 1'b0;
        end else begin
            data_ack_o <= data_req_i; // see [R9]
            data_hit_o <= data_req_i && hit;
            if (data_req_i) begin
                data_rdata_o <= rd;
            end
        end
    end
endmodule // cca_cfg_space

// *** tb/cca_cfg_props.sv ***
`timescale 1ns/1ps

module cca_cfg_props #(
    parameter HAS_GFX = 1
) (
    // Clock and reset
    input wire clk_i,
    input wire reset_i,
    // Address register
    input wire addr_we_i,
    input wire [31:0] addr_wdata_i,
    input wire [31:0] addr_rdata_o,
    // Data window
    input wire data_req_i,
    input wire data_we_i,
    input wire [31:0] data_rdata_o,
    input wire data_ack_o,
    input wire data_hit_o
);
    wire sel_on = addr_rdata_o[31];
    wire bus_zero = addr_rdata_o[23:16] == 8'h00;
    wire [4:0] sel_dev = addr_rdata_o[15:11];
    wire [2:0] sel_fn = addr_rdata_o[10:8];
    wire on_bus = sel_on && bus_zero && data_req_i;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    a_req_answered: assert property (data_req_i |=> data_ack_o) else $error("request not answered");
    a_no_stray_ack: assert property (!data_req_i |=> !data_ack_o) else $error("ack without request");
    a_window_off: assert property (data_req_i && !sel_on |=> !data_hit_o && data_rdata_o == 32'hFFFF_FFFF)
        else $error("disabled window claimed");
    a_other_bus: assert property (data_req_i && sel_on && !bus_zero |=> !data_hit_o)
        else $error("nonzero bus claimed");
    a_host_funcs: assert property (on_bus && sel_dev == 5'h00
        && (sel_fn == 3'h0 || sel_fn == 3'h1 || sel_fn == 3'h3) |=> data_hit_o) else $error("host function not claimed");
    a_absent_func: assert property (on_bus && sel_dev == 5'h00 && sel_fn == 3'h2 |=> !data_hit_o)
        else $error("absent function claimed");
    a_bridge_dev: assert property (on_bus && sel_dev == 5'h01 && sel_fn == 3'h0 |=> data_hit_o)
        else $error("bridge not claimed");
    a_gfx_dev: assert property (on_bus && sel_dev == 5'h02 && sel_fn == 3'h0 |=> data_hit_o == (HAS_GFX != 0))
        else $error("graphics claim wrong");
    a_addr_kept: assert property (addr_we_i |=> addr_rdata_o == ($past(addr_wdata_i) & 32'h80FF_FFFC))
        else $error("address register not stored");
    a_rdata_holds: assert property (!data_req_i |=> $stable(data_rdata_o)) else $error("read data moved");
    a_reserved_zero: assert property (on_bus && !data_we_i && sel_dev == 5'h00 && sel_fn == 3'h0
        && addr_rdata_o[7:2] == 6'h3F |=> data_hit_o && data_rdata_o == 32'h0000_0000) else $error("reserved read");
endmodule // cca_cfg_props

// *** tb/cca_host_model.sv ***
`timescale 1ns/1ps

// Host side; never touches vendor-reserved registers
module cca_host_model (
    // Clock
    input wire clk_i,
    // Requests
    output reg addr_we_o,
    output reg [31:0] addr_wdata_o,
    output reg req_o,
    output reg we_o,
    output reg [3:0] be_o,
    output reg [31:0] wdata_o,
    // Answers
    input wire ack_i,
    input wire hit_i,
    input wire [31:0] rdata_i
);
    initial begin
        addr_we_o = 1'b0;
        addr_wdata_o = 32'h0;
        req_o = 1'b0;
        we_o = 1'b0;
        be_o = 4'h0;
        wdata_o = 32'h0;
    end

    // Whole dword written directly, no merge
    task put_addr(input [7:0] bus, input [4:0] dev, input [2:0] fn, input [5:0] idx, input en);
        begin
            @(negedge clk_i);
            addr_we_o = 1'b1;
            addr_wdata_o = {en, 7'h00, bus, dev, fn, idx, 2'b00};
            @(negedge clk_i);
            addr_we_o = 1'b0;
            addr_wdata_o = ~addr_wdata_o;
        end
    endtask

    task xfer(input w, input [3:0] be, input [31:0] wd, output [31:0] rd, output h, output a);
        begin
            @(negedge clk_i);
            req_o = 1'b1;
            we_o = w;
            be_o = be;
            wdata_o = wd;
            @(negedge clk_i);
            req_o = 1'b0;
            wdata_o = ~wd;
            a = ack_i;
            h = hit_i;
            rd = rdata_i;
        end
    endtask

    // Keeps untouched bits by read, merge, write
    task rmw(input [31:0] mask, input [31:0] val, output [31:0] rd, output h, output a);
        reg [31:0] cur;
        begin
            xfer(1'b0, 4'hF, 32'h0, cur, h, a);
            xfer(1'b1, 4'hF, (cur & ~mask) | (val & mask), rd, h, a);
        end
    endtask
endmodule // cca_host_model

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked = samples_checked + 1; if ((g) !== (e)) begin fails = fails + 1; \
    $display("[ERR] %0t got %h want %h", $time, g, e); end end

module testbench;
    reg clk_i = 1'b0;
    reg reset_i = 1'b1;
    reg por_i = 1'b1;
    reg [7:0] strap_i = 8'h5A;
    reg [1:0] err_evt_i = 2'b00;
    wire addr_we_i, data_req_i, data_we_i, data_ack_o, data_hit_o;
    wire [3:0] data_be_i;
    wire [31:0] addr_wdata_i, addr_rdata_o, data_wdata_i, data_rdata_o;
    reg [31:0] rd;
    reg hit;
    reg ack;
    integer fails = 0;
    integer samples_checked = 0;
    // Arbitrary identity values, forced onto the design
    localparam [31:0] EXP_ID_HOST = 32'h0A00_5A01;
    localparam [31:0] EXP_ID_DRAM = 32'h0A01_5A02;
    localparam [31:0] EXP_ID_PROC = 32'h0A03_5A03;
    localparam [31:0] EXP_ID_P2P = 32'h0A10_5A04;
    localparam [31:0] EXP_ID_GFX = 32'h0A20_5A05;

    always #20 clk_i = ~clk_i;

    cca_cfg_space #(.ID_HOST(EXP_ID_HOST), .ID_DRAM(EXP_ID_DRAM), .ID_PROC(EXP_ID_PROC), .ID_P2P(EXP_ID_P2P),
        .ID_GFX(EXP_ID_GFX)) i_cca_cfg_space (.clk_i(clk_i), .reset_i(reset_i), .por_i(por_i), .strap_i(strap_i),
        .err_evt_i(err_evt_i), .addr_we_i(addr_we_i), .addr_wdata_i(addr_wdata_i), .addr_rdata_o(addr_rdata_o),
        .data_req_i(data_req_i), .data_we_i(data_we_i), .data_be_i(data_be_i), .data_wdata_i(data_wdata_i),
        .data_rdata_o(data_rdata_o), .data_ack_o(data_ack_o), .data_hit_o(data_hit_o));
    cca_host_model u_host (.clk_i(clk_i), .addr_we_o(addr_we_i), .addr_wdata_o(addr_wdata_i), .req_o(data_req_i),
        .we_o(data_we_i), .be_o(data_be_i), .wdata_o(data_wdata_i), .ack_i(data_ack_o), .hit_i(data_hit_o),
        .rdata_i(data_rdata_o));

    task do_reset(input p);
        begin
            @(negedge clk_i);
            reset_i = 1'b1;
            por_i = p;
            repeat (8) @(negedge clk_i);
            reset_i = 1'b0;
            por_i = 1'b0;
            repeat (2) @(negedge clk_i);
        end
    endtask

    task go(input [7:0] bus, input [4:0] dev, input [2:0] fn, input [5:0] idx);
        u_host.put_addr(bus, dev, fn, idx, 1'b1);
    endtask

    task wr(input [3:0] be, input [31:0] wd);
        u_host.xfer(1'b1, be, wd, rd, hit, ack);
    endtask

    task rd_exp(input [31:0] exp, input eh);
        begin
            u_host.xfer(1'b0, 4'hF, 32'h0, rd, hit, ack);
            `CHK(ack, 1'b1)
            `CHK(hit, eh)
            `CHK(rd, exp)
        end
    endtask

    task t_defaults;
        begin
            go(8'h00, 5'h00, 3'h0, 6'h14); rd_exp(32'h0000_0400, 1'b1);
            go(8'h00, 5'h01, 3'h0, 6'h07); rd_exp(32'h0000_00F0, 1'b1);
            go(8'h00, 5'h01, 3'h0, 6'h08); rd_exp(32'h0000_FFF0, 1'b1);
            go(8'h00, 5'h00, 3'h1, 6'h18); rd_exp(32'h0000_005A, 1'b1);
        end
    endtask

    task t_enum;
        begin
            go(8'h00, 5'h00, 3'h0, 6'h00); rd_exp(EXP_ID_HOST, 1'b1);
            go(8'h00, 5'h00, 3'h1, 6'h00); rd_exp(EXP_ID_DRAM, 1'b1);
            go(8'h00, 5'h00, 3'h3, 6'h00); rd_exp(EXP_ID_PROC, 1'b1);
            go(8'h00, 5'h00, 3'h2, 6'h00); rd_exp(32'hFFFF_FFFF, 1'b0);
            go(8'h00, 5'h01, 3'h0, 6'h00); rd_exp(EXP_ID_P2P, 1'b1);
            go(8'h00, 5'h02, 3'h0, 6'h00); rd_exp(EXP_ID_GFX, 1'b1);
            go(8'h00, 5'h03, 3'h0, 6'h00); rd_exp(32'hFFFF_FFFF, 1'b0);
            go(8'h01, 5'h00, 3'h0, 6'h00); rd_exp(32'hFFFF_FFFF, 1'b0);
            `CHK(addr_rdata_o, 32'h8001_0000)
            u_host.put_addr(8'h00, 5'h00, 3'h0, 6'h00, 1'b0); rd_exp(32'hFFFF_FFFF, 1'b0);
        end
    endtask

    task t_wclear;
        begin
            @(negedge clk_i);
            err_evt_i = 2'b11;
            @(negedge clk_i);
            err_evt_i = 2'b00;
            go(8'h00, 5'h00, 3'h0, 6'h01); rd_exp(32'h3000_0000, 1'b1);
            wr(4'hF, 32'h0000_0000); rd_exp(32'h3000_0000, 1'b1);
            wr(4'h8, 32'h1000_0000); rd_exp(32'h2000_0000, 1'b1);
        end
    endtask

    task t_ronly;
        begin
            go(8'h00, 5'h00, 3'h0, 6'h00); wr(4'hF, 32'h0000_0000); rd_exp(EXP_ID_HOST, 1'b1);
            go(8'h00, 5'h01, 3'h0, 6'h06); wr(4'hF, 32'hFFFF_FFFF); rd_exp(32'h00FF_FF00, 1'b1);
        end
    endtask

    task t_once;
        begin
            go(8'h00, 5'h00, 3'h0, 6'h14); wr(4'h4, 32'h00A5_0000); rd_exp(32'h00A5_0400, 1'b1);
            wr(4'h4, 32'h003C_0000); rd_exp(32'h00A5_0400, 1'b1);
            do_reset(1'b0);
            go(8'h00, 5'h00, 3'h0, 6'h14); wr(4'h4, 32'h003C_0000); rd_exp(32'h0000_0400, 1'b1);
            do_reset(1'b1);
            go(8'h00, 5'h00, 3'h0, 6'h14); wr(4'h4, 32'h003C_0000); rd_exp(32'h003C_0400, 1'b1);
        end
    endtask

    task t_lock;
        begin
            go(8'h00, 5'h00, 3'h0, 6'h15); wr(4'hF, 32'h1234_5678); rd_exp(32'h1234_5678, 1'b1);
            go(8'h00, 5'h00, 3'h0, 6'h14); u_host.rmw(32'h0000_0001, 32'h0000_0001, rd, hit, ack);
            go(8'h00, 5'h00, 3'h0, 6'h15); wr(4'hF, 32'h0000_0000); rd_exp(32'h1234_5678, 1'b1);
        end
    endtask

    task t_reserved;
        begin
            go(8'h00, 5'h00, 3'h0, 6'h3F); wr(4'hF, 32'hFFFF_FFFF); rd_exp(32'h0000_0000, 1'b1);
        end
    endtask

    task summarize;
        begin
            $display("checked %0d mismatches %0d", samples_checked, fails);
            if (fails == 0 && samples_checked > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask

    initial begin
        do_reset(1'b1);
        t_defaults;
        t_enum;
        t_wclear;
        t_ronly;
        t_once;
        t_lock;
        t_reserved;
        summarize;
    end

    initial begin
        repeat (5000) @(posedge clk_i);
        fails = fails + 1;
        summarize;
    end
endmodule // testbench

bind cca_cfg_space cca_cfg_props #(.HAS_GFX(HAS_GFX)) i_cca_cfg_props (.clk_i(clk_i), .reset_i(reset_i),
    .addr_we_i(addr_we_i), .addr_wdata_i(addr_wdata_i), .addr_rdata_o(addr_rdata_o), .data_req_i(data_req_i),
    .data_we_i(data_we_i), .data_rdata_o(data_rdata_o), .data_ack_o(data_ack_o), .data_hit_o(data_hit_o));
